// file: design/dls_defs.vh
`ifndef DLS_DEFS_VH
`define DLS_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DLS_OFF_CTRL 8'h00
`define DLS_OFF_PHASE 8'h04
`define DLS_OFF_UL 8'h08
`define DLS_OFF_TERM 8'h0C
`define DLS_OFF_STAT 8'h10
`define DLS_OFF_CLR 8'h14
`define DLS_OFF_IEN 8'h18
`define DLS_OFF_LIVE 8'h1C
`define DLS_OFF_HELD 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DLS_CTRL_REFLOSS 0
`define DLS_CTRL_SRC_LO 4
`define DLS_CTRL_VECTOR 8
`define DLS_CTRL_LDSRC 9
`define DLS_CLR_FAULT 4
`define DLS_EV_REFLOSS 0
`define DLS_EV_INPH 1
`define DLS_EV_OUTPH 2
`define DLS_EV_UL 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DLS_RST_CTRL 32'h0000_0000
`define DLS_RST_PHASE 32'h0000_0000
`define DLS_RST_UL 32'h0001_0A00
`define DLS_RST_TERM 32'h0000_0000

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define DLS_SRC_ANA_LO 4'h2
`define DLS_SRC_ANA_HI 4'h4
`define DLS_SRC_PULSE 4'h5
`define DLS_TERM_UL_NO 8'h08
`define DLS_TERM_UL_NC 8'h09
`define DLS_UL_OFF 3'h0
`define DLS_UL_CS_CONT 3'h1
`define DLS_UL_CS_STOP 3'h2
`define DLS_UL_RUN_CONT 3'h3
`define DLS_UL_RUN_STOP 3'h4

// ----------------------------------------------------------------
// timing and levels
// ----------------------------------------------------------------
`define DLS_CLK_MHZ 250
`define DLS_TICK_MS 100
`define DLS_TICK_CYC (`DLS_TICK_MS * 1000 * `DLS_CLK_MHZ)
`define DLS_REFWIN_MS 400
`define DLS_REFWIN_TICKS (`DLS_REFWIN_MS / `DLS_TICK_MS)
`define DLS_REF_DROP_PCT 90
`define DLS_REF_KEEP_PCT 80
`define DLS_UL_HYST_PCT 8'h05
`define DLS_TICKS_PER_S 4'd10

`endif

// file: design/dls_top.v
// Notes on behaviour
// (R1) reference-loss select: 0 disables, 1 enables the processing.
// (R2) reference loss only in remote mode with analog or pulse source.
// (R3) drop of 90 % inside 400 ms: run on at 80 % of prior level.
// (R4) open-phase level 0 % disables that detector.
// (R5) open-phase time 0 s disables that detector.
// (R6) software should set input open-phase to 7 % and 10 s.
// (R7) software should set output open-phase to 5 % and 0.2 s.
// (R8) terminal function 8 gives normally-open, 9 normally-closed underload.
// (R9) underload releases only above level plus about 5 % hysteresis.
// (R10) underload mode 0 off, 1/2 constant speed, 3/4 whenever running.
// (R11) modes 1 and 3 keep running with a flashing indication.
// (R12) modes 2 and 4 stop with a fault and steady indication.
// (R13) underload level in 1 % steps, default 10 %.
// (R14) detect after staying below level longer than time, default 0.1 s.
// (R15) vector control: select 0 torque, 1 current; V/f always current.
// (R16) underload timer restarts when value returns to level or above.
// (R17) open-phase time counted on tick; asserted after full time.
`timescale 1ns/1ps
`include "dls_defs.vh"

module dls_top #(
	parameter TICK_CYC = `DLS_TICK_CYC,
	parameter REF_W = 12
) (
	input wire pclk, // apb clock
	input wire presetn, // async reset, low active
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output wire pready, // apb ready
	output reg [31:0] prdata, // apb read data
	output wire pslverr, // apb error, unmapped
	input wire remote_mode, // drive in remote mode
	input wire running, // drive running
	input wire at_speed, // constant-speed running
	input wire [REF_W-1:0] ref_in, // measured reference
	input wire [7:0] in_phase_pct, // input open-phase measure
	input wire [7:0] out_phase_pct, // output open-phase measure
	input wire [7:0] current_pct, // output current, % rated
	input wire [7:0] torque_pct, // output torque, % rated
	output reg [REF_W-1:0] ref_out, // reference used by drive
	output reg in_phase_loss, // input open-phase detected
	output reg out_phase_loss, // output open-phase detected
	output reg ul_detect, // underload detected
	output reg ul_fault, // underload stop fault
	output reg ul_ind_on, // indication steadily lit
	output reg ul_ind_flash, // indication flashing
	output reg [2:0] term_out, // terminals a, b, c
	output wire irq // level interrupt
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function term_drive;
		input [7:0] func;
		input det;
		begin
			if (func == `DLS_TERM_UL_NO)
				term_drive = det; // R8
			else if (func == `DLS_TERM_UL_NC)
				term_drive = ~det; // R8
			else
				term_drive = 1'b0;
		end
	endfunction

	function src_ok;
		input [3:0] src;
		begin
			src_ok = ((src >= `DLS_SRC_ANA_LO) && (src <= `DLS_SRC_ANA_HI))
				|| (src == `DLS_SRC_PULSE); // R2
		end
	endfunction

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	reg [31:0] ctrl_r;
	reg [31:0] phase_r;
	reg [31:0] ul_r;
	reg [31:0] term_r;
	reg [3:0] stat_r;
	reg [3:0] ien_r;
	reg [3:0] ev;
	reg mapped;
	wire setup = psel & ~penable;
	wire wr_acc = psel & penable & pwrite;
	wire clr_wr = wr_acc & (paddr == `DLS_OFF_CLR);

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign irq = |(stat_r & ien_r);

	always @* begin
		case (paddr)
			`DLS_OFF_CTRL, `DLS_OFF_PHASE, `DLS_OFF_UL, `DLS_OFF_TERM,
			`DLS_OFF_STAT, `DLS_OFF_CLR, `DLS_OFF_IEN, `DLS_OFF_LIVE,
			`DLS_OFF_HELD: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	wire [3:0] ref_src = ctrl_r[`DLS_CTRL_SRC_LO+3:`DLS_CTRL_SRC_LO];
	wire [7:0] in_lvl = phase_r[7:0];
	wire [7:0] in_time = phase_r[15:8];
	wire [7:0] out_lvl = phase_r[23:16];
	wire [7:0] out_time = phase_r[31:24];
	wire [2:0] ul_mode = ul_r[2:0];
	wire [7:0] ul_lvl = ul_r[15:8];
	wire [7:0] ul_time = ul_r[23:16];
	reg ref_lost_r;
	reg [REF_W-1:0] held_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `DLS_RST_CTRL;
			phase_r <= `DLS_RST_PHASE;
			ul_r <= `DLS_RST_UL;
			term_r <= `DLS_RST_TERM;
			ien_r <= 4'h0;
			stat_r <= 4'h0;
			prdata <= 32'h0000_0000;
		end else begin
			if (wr_acc) begin
				case (paddr)
					`DLS_OFF_CTRL: ctrl_r <= pwdata;
					`DLS_OFF_PHASE: phase_r <= pwdata;
					`DLS_OFF_UL: ul_r <= pwdata;
					`DLS_OFF_TERM: term_r <= pwdata;
					`DLS_OFF_IEN: ien_r <= pwdata[3:0];
					default: ;
				endcase
			end
			// set wins over clear
			stat_r <= (stat_r & ~(clr_wr ? pwdata[3:0] : 4'h0)) | ev;
			if (setup) begin
				case (paddr)
					`DLS_OFF_CTRL: prdata <= ctrl_r;
					`DLS_OFF_PHASE: prdata <= phase_r;
					`DLS_OFF_UL: prdata <= ul_r;
					`DLS_OFF_TERM: prdata <= term_r;
					`DLS_OFF_STAT: prdata <= {28'h000_0000, stat_r};
					`DLS_OFF_IEN: prdata <= {28'h000_0000, ien_r};
					`DLS_OFF_LIVE: prdata <= {26'h0_0000, ul_fault,
						ul_detect, out_phase_loss, in_phase_loss,
						ref_lost_r};
					`DLS_OFF_HELD: prdata <= {{(32-REF_W){1'b0}}, held_r};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// time base, one tick per 100 ms
	// ----------------------------------------------------------------
	reg [31:0] tick_cnt_r;
	wire tick = (tick_cnt_r == TICK_CYC - 1);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_cnt_r <= 32'h0000_0000;
		else if (tick)
			tick_cnt_r <= 32'h0000_0000;
		else
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
	end

	// ----------------------------------------------------------------
	// reference loss
	// ----------------------------------------------------------------
	reg [REF_W-1:0] hist_r [0:`DLS_REFWIN_TICKS-1];
	reg [REF_W-1:0] hist_max;
	integer k;
	wire rl_on = ctrl_r[`DLS_CTRL_REFLOSS] & remote_mode & src_ok(ref_src);
	wire [REF_W+7:0] now_x100 = ref_in * 8'd100;
	wire [31:0] max_x_rem = hist_max * (100 - `DLS_REF_DROP_PCT);
	wire [31:0] keep_full = hist_max * `DLS_REF_KEEP_PCT / 100;
	wire drop = (hist_max != {REF_W{1'b0}}) & (now_x100 <= max_x_rem);

	always @* begin
		hist_max = {REF_W{1'b0}};
		for (k = 0; k < `DLS_REFWIN_TICKS; k = k + 1)
			if (hist_r[k] > hist_max)
				hist_max = hist_r[k];
	end

	genvar g;
	generate
		for (g = 0; g < `DLS_REFWIN_TICKS; g = g + 1) begin : g_hist
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					hist_r[g] <= {REF_W{1'b0}};
				else if (tick)
					hist_r[g] <= (g == 0) ? ref_in :
						hist_r[(g > 0) ? g - 1 : 0];
			end
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_lost_r <= 1'b0;
			held_r <= {REF_W{1'b0}};
			ref_out <= {REF_W{1'b0}};
		end else begin
			if (!rl_on) // R1
				ref_lost_r <= 1'b0;
			else if (!ref_lost_r && drop) begin
				ref_lost_r <= 1'b1; // R3
				held_r <= keep_full[REF_W-1:0]; // R3
			end else if (ref_lost_r && ref_in >= held_r)
				ref_lost_r <= 1'b0;
			ref_out <= ref_lost_r ? held_r : ref_in; // R3
		end
	end

	// ----------------------------------------------------------------
	// open-phase detectors, 0: input (1 s), 1: output (0.1 s)
	// ----------------------------------------------------------------
	wire [7:0] op_meas [0:1];
	wire [7:0] op_lvl [0:1];
	wire [11:0] op_tgt [0:1];
	reg [11:0] op_cnt_r [0:1];
	reg [1:0] op_det_r;
	assign op_meas[0] = in_phase_pct;
	assign op_meas[1] = out_phase_pct;
	assign op_lvl[0] = in_lvl;
	assign op_lvl[1] = out_lvl;
	assign op_tgt[0] = in_time * `DLS_TICKS_PER_S;
	assign op_tgt[1] = {4'h0, out_time};

	generate
		for (g = 0; g < 2; g = g + 1) begin : g_op
			wire en = (op_lvl[g] != 8'h00) & (op_tgt[g] != 12'h000); // R4 R5
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					op_cnt_r[g] <= 12'h000;
					op_det_r[g] <= 1'b0;
				end else if (!en || op_meas[g] < op_lvl[g]) begin
					op_cnt_r[g] <= 12'h000;
					op_det_r[g] <= 1'b0;
				end else if (tick) begin
					if (op_cnt_r[g] + 12'h001 >= op_tgt[g])
						op_det_r[g] <= 1'b1; // R17
					else
						op_cnt_r[g] <= op_cnt_r[g] + 12'h001; // R17
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// underload
	// ----------------------------------------------------------------
	reg [8:0] ul_cnt_r;
	wire use_torque = ctrl_r[`DLS_CTRL_VECTOR] & ~ctrl_r[`DLS_CTRL_LDSRC];
	wire [7:0] ul_meas = use_torque ? torque_pct : current_pct; // R15
	wire ul_stop = (ul_mode == `DLS_UL_CS_STOP) ||
		(ul_mode == `DLS_UL_RUN_STOP);
	reg ul_window;
	wire ul_below = ul_meas < ul_lvl; // R13
	wire [8:0] rel_lvl = {1'b0, ul_lvl} + {1'b0, `DLS_UL_HYST_PCT};
	wire fault_clr = clr_wr & pwdata[`DLS_CLR_FAULT];

	always @* begin
		case (ul_mode) // R10
			`DLS_UL_CS_CONT, `DLS_UL_CS_STOP: ul_window = running & at_speed;
			`DLS_UL_RUN_CONT, `DLS_UL_RUN_STOP: ul_window = running;
			default: ul_window = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ul_cnt_r <= 9'h000;
			ul_detect <= 1'b0;
			ul_fault <= 1'b0;
		end else begin
			if (!ul_window || !ul_below)
				ul_cnt_r <= 9'h000; // R16
			else if (tick && ul_cnt_r <= {1'b0, ul_time})
				ul_cnt_r <= ul_cnt_r + 9'h001;
			if (ul_mode == `DLS_UL_OFF)
				ul_detect <= 1'b0;
			else if (!ul_detect && ul_window && ul_below &&
				ul_cnt_r > {1'b0, ul_time})
				ul_detect <= 1'b1; // R14
			else if (ul_detect && {1'b0, ul_meas} > rel_lvl)
				ul_detect <= 1'b0; // R9
			if (ul_detect && ul_stop)
				ul_fault <= 1'b1; // R12
			else if (fault_clr)
				ul_fault <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_phase_loss <= 1'b0;
			out_phase_loss <= 1'b0;
			ul_ind_on <= 1'b0;
			ul_ind_flash <= 1'b0;
			term_out <= 3'b000;
		end else begin
			in_phase_loss <= op_det_r[0];
			out_phase_loss <= op_det_r[1];
			ul_ind_on <= ul_fault; // R12
			ul_ind_flash <= ul_detect & ~ul_stop & ~ul_fault; // R11
			term_out[0] <= term_drive(term_r[7:0], ul_detect); // R8
			term_out[1] <= term_drive(term_r[15:8], ul_detect); // R8
			term_out[2] <= term_drive(term_r[23:16], ul_detect); // R8
		end
	end

	// ----------------------------------------------------------------
	// events: rising edges of each condition
	// ----------------------------------------------------------------
	reg [3:0] cond_d_r;
	wire [3:0] cond = {ul_detect, op_det_r[1], op_det_r[0], ref_lost_r};

	always @* begin
		ev = cond & ~cond_d_r;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cond_d_r <= 4'h0;
		else
			cond_d_r <= cond;
	end

endmodule

// file: dv/dls_props.sv
`timescale 1ns/1ps

module dls_props (
	input wire pclk, // clock
	input wire presetn, // async reset, low active
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [7:0] paddr, // apb address
	input wire pready, // apb ready
	input wire [31:0] prdata, // apb read data
	input wire pslverr, // apb error
	input wire running, // drive running
	input wire [7:0] in_phase_pct, // input phase measure
	input wire [7:0] out_phase_pct, // output phase measure
	input wire in_phase_loss, // input open phase
	input wire out_phase_loss, // output open phase
	input wire ul_detect, // underload detected
	input wire ul_fault, // underload fault
	input wire ul_ind_on, // steady indication
	input wire ul_ind_flash, // flashing indication
	input wire [2:0] term_out // terminals
);
	wire bad = paddr > 8'h20 || paddr[1:0] != 2'b00;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_high_a: assert property (pready)
		else $error("pready low");
	slverr_map_a: assert property (pslverr == (psel && penable && bad))
		else $error("pslverr wrong");
	rd_zero_a: assert property (psel && penable && !pwrite && bad |->
		prdata == 32'h0000_0000) else $error("unmapped read not zero");
	reset_out_a: assert property ($rose(presetn) |-> !in_phase_loss &&
		!ul_detect && !ul_fault && term_out == 3'h0)
		else $error("outputs not cleared by reset");
	in_level_a: assert property (in_phase_loss |->
		$past(in_phase_pct) != 0 || $past(in_phase_pct, 2) != 0 ||
		$past(in_phase_pct, 3) != 0)
		else $error("input loss with zero measure");
	out_level_a: assert property (out_phase_loss |->
		$past(out_phase_pct) != 0 || $past(out_phase_pct, 2) != 0 ||
		$past(out_phase_pct, 3) != 0)
		else $error("output loss with zero measure");
	ul_run_a: assert property ($rose(ul_detect) |-> $past(running) ||
		$past(running, 2)) else $error("underload while stopped");
	fault_det_a: assert property ($rose(ul_fault) |-> $past(ul_detect))
		else $error("fault without detection");
	flash_det_a: assert property (ul_ind_flash |-> ul_detect ||
		$past(ul_detect)) else $error("flash without detection");
	steady_ind_a: assert property (ul_ind_on |-> ul_fault ||
		$past(ul_fault)) else $error("steady indication without fault");
endmodule

bind dls_top dls_props i_dls_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .running(running),
	.in_phase_pct(in_phase_pct), .out_phase_pct(out_phase_pct),
	.in_phase_loss(in_phase_loss), .out_phase_loss(out_phase_loss),
	.ul_detect(ul_detect), .ul_fault(ul_fault), .ul_ind_on(ul_ind_on),
	.ul_ind_flash(ul_ind_flash), .term_out(term_out));

// file: dv/dls_meas_model.sv
`timescale 1ns/1ps

// measurement path: set points reach the block one clock later
module dls_meas_model (
	input wire pclk, // clock
	input wire [11:0] set_ref, // reference set point
	input wire [7:0] set_inp, // input phase set point
	input wire [7:0] set_outp, // output phase set point
	input wire [7:0] set_cur, // current set point
	input wire [7:0] set_trq, // torque set point
	output reg [11:0] ref_in = 12'h000, // measured reference
	output reg [7:0] inp = 8'h00, // input phase measure
	output reg [7:0] outp = 8'h00, // output phase measure
	output reg [7:0] cur = 8'h00, // current measure
	output reg [7:0] trq = 8'h00 // torque measure
);
	always @(posedge pclk) begin
		ref_in <= set_ref;
		inp <= set_inp;
		outp <= set_outp;
		cur <= set_cur;
		trq <= set_trq;
	end
endmodule

// file: dv/dls_top_tb.sv
`timescale 1ns/1ps
`include "dls_defs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end

module dls_top_tb;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg [7:0] paddr = 0, s_inp = 0, s_outp = 0, s_cur = 0, s_trq = 0;
	reg [31:0] pwdata = 0, d;
	reg remote_mode = 0, running = 0, at_speed = 0, e;
	reg [11:0] s_ref = 0;
	wire pready, pslverr, irq, inl, outl, uld, ulf, ulon, ulfl;
	wire [31:0] prdata;
	wire [11:0] ref_in, ref_out;
	wire [7:0] inp, outp, cur, trq;
	wire [2:0] term_out;
	int error_cnt = 0, check_count = 0, i;
	always #2 pclk = ~pclk;
	dls_meas_model i_dls_meas_model (.pclk(pclk), .set_ref(s_ref),
		.set_inp(s_inp), .set_outp(s_outp), .set_cur(s_cur),
		.set_trq(s_trq), .ref_in(ref_in), .inp(inp), .outp(outp),
		.cur(cur), .trq(trq));
	dls_top #(.TICK_CYC(10)) i_dls_top (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .remote_mode(remote_mode), .running(running),
		.at_speed(at_speed), .ref_in(ref_in), .in_phase_pct(inp),
		.out_phase_pct(outp), .current_pct(cur), .torque_pct(trq),
		.ref_out(ref_out), .in_phase_loss(inl), .out_phase_loss(outl),
		.ul_detect(uld), .ul_fault(ulf), .ul_ind_on(ulon),
		.ul_ind_flash(ulfl), .term_out(term_out), .irq(irq));
	// ----------------------------------------------------------------
	// apb access
	// ----------------------------------------------------------------
	task xfer(input w, input [7:0] a, input [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input [7:0] a, input [31:0] v);
		xfer(1'b1, a, v);
	endtask
	task rd(input [7:0] a, input [31:0] x);
		xfer(1'b0, a, 32'h0000_0000);
		`CHK(d, x)
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task test_done;
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		cyc(20000);
		error_cnt++;
		test_done;
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		cyc(2);
		presetn <= 1'b1;
		rd(`DLS_OFF_CTRL, 32'h0000_0000);
		rd(`DLS_OFF_PHASE, 32'h0000_0000);
		rd(`DLS_OFF_UL, 32'h0001_0A00);
		rd(`DLS_OFF_TERM, 32'h0000_0000);
		rd(`DLS_OFF_STAT, 32'h0000_0000);
		rd(`DLS_OFF_IEN, 32'h0000_0000);
		xfer(1'b0, 8'h24, 32'h0000_0000);
		`CHK({e, d}, 33'h1_0000_0000)
		running <= 1'b1;
		s_inp <= 8'd50;
		s_outp <= 8'd10;
		wr(`DLS_OFF_PHASE, 32'h0205_0007);
		wr(`DLS_OFF_IEN, 32'h0000_0006);
		cyc(60);
		`CHK(outl, 1'b1)
		`CHK(inl, 1'b0)
		`CHK(irq, 1'b1)
		wr(`DLS_OFF_PHASE, 32'h0205_0A00);
		cyc(1100);
		`CHK(inl, 1'b0)
		wr(`DLS_OFF_PHASE, 32'h0205_0A07);
		cyc(500);
		`CHK(inl, 1'b0)
		cyc(700);
		`CHK(inl, 1'b1)
		rd(`DLS_OFF_STAT, 32'h0000_0006);
		wr(`DLS_OFF_IEN, 32'h0000_0000);
		cyc(1);
		`CHK(irq, 1'b0)
		wr(`DLS_OFF_IEN, 32'h0000_0006);
		wr(`DLS_OFF_CLR, 32'h0000_0006);
		rd(`DLS_OFF_STAT, 32'h0000_0000);
		`CHK(irq, 1'b0)
		s_cur <= 8'd50;
		wr(`DLS_OFF_TERM, 32'h0000_0908);
		for (i = 0; i < 5; i++) begin
			wr(`DLS_OFF_UL, 32'h0001_0A00 | i);
			s_cur <= 8'd5;
			cyc(40);
			`CHK(uld, i > 2)
			`CHK(term_out, {1'b0, i < 3, i > 2})
			`CHK(ulfl, i == 3)
			`CHK(ulf, i == 4)
			`CHK(ulon, i == 4)
			s_cur <= 8'd50;
			cyc(30);
			wr(`DLS_OFF_CLR, 32'h0000_0018);
		end
		cyc(1);
		`CHK(ulf, 1'b0)
		at_speed <= 1'b1;
		wr(`DLS_OFF_UL, 32'h0003_0A01);
		s_cur <= 8'd5;
		cyc(25);
		s_cur <= 8'd50;
		cyc(3);
		s_cur <= 8'd5;
		cyc(25);
		`CHK(uld, 1'b0)
		cyc(20);
		`CHK(uld, 1'b1)
		s_cur <= 8'd15;
		cyc(10);
		`CHK(uld, 1'b1)
		s_cur <= 8'd16;
		cyc(10);
		`CHK(uld, 1'b0)
		s_cur <= 8'd50;
		s_trq <= 8'd5;
		wr(`DLS_OFF_CTRL, 32'h0000_0100);
		cyc(50);
		`CHK(uld, 1'b1)
		wr(`DLS_OFF_CTRL, 32'h0000_0300);
		cyc(10);
		`CHK(uld, 1'b0)
		wr(`DLS_OFF_CTRL, 32'h0000_0021);
		s_ref <= 12'd1000;
		cyc(60);
		`CHK(ref_out, 12'd1000)
		s_ref <= 12'd50;
		cyc(6);
		`CHK(ref_out, 12'd50)
		s_ref <= 12'd1000;
		cyc(60);
		remote_mode <= 1'b1;
		s_ref <= 12'd50;
		cyc(6);
		`CHK(ref_out, 12'd800)
		rd(`DLS_OFF_HELD, 32'h0000_0320);
		rd(`DLS_OFF_LIVE, 32'h0000_0007);
		wr(`DLS_OFF_CTRL, 32'h0000_0020);
		cyc(4);
		`CHK(ref_out, 12'd50)
		test_done;
	end
endmodule
